// *** inc/einp_cfg.svh ***
// constants for the extra interrupt controller and four-bit port
// assumes a special-function bus with byte and bit accesses from the core
`ifndef EINP_CFG_SVH
`define EINP_CFG_SVH

// special-function byte addresses
`define EINP_ADDR_XCTRL      8'hC0
`define EINP_ADDR_PORT       8'hD8

// bit addresses: upper five bits select the register, low three the bit
`define EINP_BITBASE_XCTRL   5'b1100_0
`define EINP_BITBASE_PORT    5'b1101_1

// ext_irq_control field positions
`define EINP_F_TWO_TRIG      0
`define EINP_F_TWO_PEND      1
`define EINP_F_TWO_EN        2
`define EINP_F_TWO_PRIO      3
`define EINP_F_THREE_TRIG    4
`define EINP_F_THREE_PEND    5
`define EINP_F_THREE_EN      6
`define EINP_F_THREE_PRIO    7

// standard register fields seen from the core
`define EINP_F_GLOBAL_EN     7
`define EINP_F_ZERO_TRIG     0
`define EINP_F_ONE_TRIG      2

// port pins shared with interrupt inputs
`define EINP_PIN_TWO         2
`define EINP_PIN_THREE       3

// reset values, and the value read from the unused upper port bits
`define EINP_RST_XCTRL       8'h00
`define EINP_RST_PORT        4'hF
`define EINP_PORT_UNUSED     4'h0

// vectors: first vector and spacing between sources
`define EINP_VEC_BASE        8'h03
`define EINP_VEC_STEP        8'h08

// oscillator periods in one machine cycle
`define EINP_MCYC_CLKS       4'hC

`endif

// *** inc/einp_pkg.sv ***
// types for the extra interrupt controller and four-bit port
// assumes einp_cfg.svh supplies the numeric constants
package einp_pkg;

  // source index, also the polling order within one level
  typedef enum logic [2:0] {
    SRC_EXT_ZERO,
    SRC_TIMER_ZERO,
    SRC_EXT_ONE,
    SRC_TIMER_ONE,
    SRC_SERIAL,
    SRC_TIMER_TWO,
    SRC_EXT_TWO,
    SRC_EXT_THREE
  } einp_src_t;

  typedef logic [7:0] einp_srcvec_t;

endpackage

// *** rtl/einp_sync2.sv ***
// two-flop synchroniser for pins from outside the clock domain
// assumes a synchronous active-high reset; resets to all ones (pulled-up pins)
`timescale 1ns/1ns
`default_nettype none

module einp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output var  logic [W-1:0] o_sync
);

  logic [W-1:0] meta_r;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_r <= '1;
      o_sync <= '1;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule // einp_sync2

`default_nettype wire

// *** rtl/einp_ext_irq_det.sv ***
// one external interrupt: machine-cycle sampling, edge or level request flag
// assumes a synchronised pin and a one-cycle machine-cycle enable
`timescale 1ns/1ns
`default_nettype none

module einp_ext_irq_det (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_mcyc_en,
  input  wire logic i_pin,
  input  wire logic i_edge_mode,
  input  wire logic i_sw_wr,
  input  wire logic i_sw_val,
  input  wire logic i_ack_clr,
  output var  logic o_pending
);

  logic sample_r;
  logic edge_set;

  // high sample then low sample one machine cycle later
  assign edge_set = i_mcyc_en & sample_r & ~i_pin;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sample_r <= 1'b1;
    end else if (i_mcyc_en) begin
      sample_r <= i_pin;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pending <= 1'b0;
    end else if (i_edge_mode) begin
      // a detected edge wins over a software clear or a vectoring clear
      if (edge_set) begin
        o_pending <= 1'b1;
      end else if (i_sw_wr) begin
        o_pending <= i_sw_val;
      end else if (i_ack_clr) begin
        o_pending <= 1'b0;
      end
    end else if (i_mcyc_en) begin
      // level mode: flag follows the sampled low level, nothing latched
      o_pending <= ~i_pin;
    end
  end

endmodule // einp_ext_irq_det

`default_nettype wire

// *** rtl/einp_ext_irq_and_nibble_port.sv ***
// extra external interrupts, eight-source arbiter and four-bit port
// assumes the core drives the special-function bus and vectoring handshake
// Functional notes
// - extra interrupt control at 0C0H, bit-addressable; bit 0C2H is interrupt-two enable
// - trigger bit 1 means falling edge, 0 means low level request
// - edge mode: flag set by hardware on edge, cleared when vectored
// - interrupt two needs bit 2 enable, interrupt three needs bit 6
// - priority bit set means high level, clear means low level
// - vectors 03H to 2BH for standard sources, 33H and 3BH for new
// - same-level polling order: ext0, t0, ext1, t1, serial, t2, ext2, ext3
// - enable bits 0-5 gate standard sources; timer-control bits 0,2 pick trigger
// - four-bit bit-addressable port at 0D8H behaving like the first port
// - port bits 3 and 2 double as interrupt three and two inputs
// - writes drive latches; reads return port state for read-modify-write
// - quasi-bidirectional pins with pull-ups; write 1 to use as input
// - reset sets port latches to ones and control register to zero
`timescale 1ns/1ns
`default_nettype none
`include "einp_cfg.svh"

module einp_ext_irq_and_nibble_port
  import einp_pkg::*;
(
  input  wire logic       I_MCLK,
  input  wire logic       I_SRST,
  // special-function byte access
  input  wire logic [7:0] I_SFR_ADDR,
  input  wire logic       I_SFR_WR,
  input  wire logic [7:0] I_SFR_WDATA,
  input  wire logic       I_SFR_RD,
  input  wire logic       I_SFR_RMW,
  output logic      [7:0] O_SFR_RDATA,
  output logic            O_SFR_HIT,
  // special-function bit access
  input  wire logic [7:0] I_BIT_ADDR,
  input  wire logic       I_BIT_WR,
  input  wire logic       I_BIT_WDATA,
  input  wire logic       I_BIT_RD,
  output logic            O_BIT_RDATA,
  // standard register contents held by the core
  input  wire logic [7:0] I_IRQ_ENABLE_REG,
  input  wire logic [7:0] I_TIMER_CTRL_REG,
  input  wire logic [5:0] I_STD_PRIORITY,
  input  wire logic [3:0] I_STD_IRQ,
  // external pins
  input  wire logic       I_EXT_IRQ_ZERO_PIN,
  input  wire logic       I_EXT_IRQ_ONE_PIN,
  input  wire logic [3:0] I_AUX_NIBBLE_PORT_IN,
  output logic      [3:0] O_AUX_NIBBLE_PORT_OUT,
  output logic      [3:0] O_AUX_NIBBLE_PORT_OE_N,
  // vectoring handshake with the core
  output logic            O_IRQ_REQ,
  output logic      [7:0] O_IRQ_VECTOR,
  output logic      [7:0] O_IRQ_ACK_SRC,
  output logic      [1:0] O_EXT_ZERO_ONE_PENDING,
  input  wire logic       I_IRQ_ACK,
  input  wire logic       I_IRQ_RETI
);

  // ==========================================================
  // machine-cycle enable
  // ==========================================================
  logic [3:0] mcyc_cnt_r;
  logic       mcyc_en_r;

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      mcyc_cnt_r <= 4'h0;
      mcyc_en_r  <= 1'b0;
    end else if (mcyc_cnt_r == `EINP_MCYC_CLKS - 4'h1) begin
      mcyc_cnt_r <= 4'h0;
      mcyc_en_r  <= 1'b1;
    end else begin
      mcyc_cnt_r <= mcyc_cnt_r + 4'h1;
      mcyc_en_r  <= 1'b0;
    end
  end

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [3:0] port_pin_s;
  logic [1:0] ext01_pin_s;

  einp_sync2 #(.W(4)) u_sync_port (
    .i_clk   (I_MCLK),
    .i_rst   (I_SRST),
    .i_async (I_AUX_NIBBLE_PORT_IN),
    .o_sync  (port_pin_s)
  );

  einp_sync2 #(.W(2)) u_sync_ext01 (
    .i_clk   (I_MCLK),
    .i_rst   (I_SRST),
    .i_async ({I_EXT_IRQ_ONE_PIN, I_EXT_IRQ_ZERO_PIN}),
    .o_sync  (ext01_pin_s)
  );

  // ==========================================================
  // address decode
  // ==========================================================
  logic       wr_xctrl;
  logic       wr_port;
  logic       bit_xctrl;
  logic       bit_port;
  logic       bwr_xctrl;
  logic       bwr_port;
  logic [2:0] bit_idx;

  assign wr_xctrl  = I_SFR_WR && (I_SFR_ADDR == `EINP_ADDR_XCTRL);
  assign wr_port   = I_SFR_WR && (I_SFR_ADDR == `EINP_ADDR_PORT);
  assign bit_xctrl = (I_BIT_ADDR[7:3] == `EINP_BITBASE_XCTRL);
  assign bit_port  = (I_BIT_ADDR[7:3] == `EINP_BITBASE_PORT) && !I_BIT_ADDR[2];
  assign bwr_xctrl = I_BIT_WR && bit_xctrl;
  assign bwr_port  = I_BIT_WR && bit_port;
  assign bit_idx   = I_BIT_ADDR[2:0];

  // ==========================================================
  // ext_irq_control: plain control bits
  // ==========================================================
  logic [7:0] xctrl_r;
  logic [7:0] xctrl_wmask;
  logic [7:0] xctrl_wval;

  always_comb begin
    xctrl_wmask = 8'h00;
    xctrl_wval  = I_SFR_WDATA;
    if (wr_xctrl) begin
      xctrl_wmask = 8'hFF;
    end else if (bwr_xctrl) begin
      xctrl_wmask = 8'h01 << bit_idx;
      xctrl_wval  = {8{I_BIT_WDATA}};
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      xctrl_r <= `EINP_RST_XCTRL;
    end else begin
      xctrl_r <= (xctrl_r & ~xctrl_wmask) | (xctrl_wval & xctrl_wmask);
    end
  end

  // ==========================================================
  // external interrupt detectors
  // ==========================================================
  logic [3:0] ext_pend;
  logic [3:0] ext_pin;
  logic [3:0] ext_edge;
  logic [3:0] ext_sw_wr;
  logic [3:0] ext_sw_val;
  logic [3:0] ext_ack;
  logic [7:0] ack_src_nxt;

  assign ext_pin  = {port_pin_s[`EINP_PIN_THREE], port_pin_s[`EINP_PIN_TWO],
                     ext01_pin_s};
  assign ext_edge = {xctrl_r[`EINP_F_THREE_TRIG], xctrl_r[`EINP_F_TWO_TRIG],
                     I_TIMER_CTRL_REG[`EINP_F_ONE_TRIG],
                     I_TIMER_CTRL_REG[`EINP_F_ZERO_TRIG]};
  assign ext_sw_wr  = {xctrl_wmask[`EINP_F_THREE_PEND], xctrl_wmask[`EINP_F_TWO_PEND],
                       2'b00};
  assign ext_sw_val = {xctrl_wval[`EINP_F_THREE_PEND], xctrl_wval[`EINP_F_TWO_PEND],
                       2'b00};
  assign ext_ack    = {ack_src_nxt[SRC_EXT_THREE], ack_src_nxt[SRC_EXT_TWO],
                       ack_src_nxt[SRC_EXT_ONE], ack_src_nxt[SRC_EXT_ZERO]};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_det
      einp_ext_irq_det u_det (
        .i_clk       (I_MCLK),
        .i_rst       (I_SRST),
        .i_mcyc_en   (mcyc_en_r),
        .i_pin       (ext_pin[g]),
        .i_edge_mode (ext_edge[g]),
        .i_sw_wr     (ext_sw_wr[g]),
        .i_sw_val    (ext_sw_val[g]),
        .i_ack_clr   (ext_ack[g]),
        .o_pending   (ext_pend[g])
      );
    end
  endgenerate

  // ==========================================================
  // arbiter
  // ==========================================================
  einp_srcvec_t pend_vec;
  einp_srcvec_t en_vec;
  einp_srcvec_t prio_vec;
  einp_srcvec_t req_vec;
  logic         isr_hi_r;
  logic         isr_lo_r;
  logic         hi_any;
  logic         lo_any;
  logic [2:0]   hi_idx;
  logic [2:0]   lo_idx;
  logic         grant_ok;
  logic         grant_hi;
  logic [2:0]   grant_idx;
  logic         sel_hi_r;
  logic [2:0]   sel_idx_r;

  assign pend_vec = {ext_pend[3], ext_pend[2], I_STD_IRQ[3], I_STD_IRQ[2],
                     I_STD_IRQ[1], ext_pend[1], I_STD_IRQ[0], ext_pend[0]};
  assign en_vec   = {xctrl_r[`EINP_F_THREE_EN], xctrl_r[`EINP_F_TWO_EN],
                     I_IRQ_ENABLE_REG[5:0]} &
                    {8{I_IRQ_ENABLE_REG[`EINP_F_GLOBAL_EN]}};
  assign prio_vec = {xctrl_r[`EINP_F_THREE_PRIO], xctrl_r[`EINP_F_TWO_PRIO],
                     I_STD_PRIORITY};
  assign req_vec  = pend_vec & en_vec;

  // scan downwards so the lowest index, first in polling order, wins
  always_comb begin
    hi_any = 1'b0;
    lo_any = 1'b0;
    hi_idx = 3'h0;
    lo_idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (req_vec[i] && prio_vec[i]) begin
        hi_any = 1'b1;
        hi_idx = 3'(i);
      end
      if (req_vec[i] && !prio_vec[i]) begin
        lo_any = 1'b1;
        lo_idx = 3'(i);
      end
    end
  end

  // high level pre-empts low service; nothing pre-empts high service
  always_comb begin
    grant_ok  = 1'b0;
    grant_hi  = 1'b0;
    grant_idx = lo_idx;
    if (!isr_hi_r) begin
      if (hi_any) begin
        grant_ok  = 1'b1;
        grant_hi  = 1'b1;
        grant_idx = hi_idx;
      end else if (lo_any && !isr_lo_r) begin
        grant_ok  = 1'b1;
      end
    end
  end

  always_comb begin
    ack_src_nxt = 8'h00;
    if (I_IRQ_ACK && O_IRQ_REQ) begin
      ack_src_nxt = 8'h01 << sel_idx_r;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_IRQ_REQ    <= 1'b0;
      O_IRQ_VECTOR <= `EINP_VEC_BASE;
      sel_hi_r     <= 1'b0;
      sel_idx_r    <= 3'h0;
    end else begin
      O_IRQ_REQ    <= grant_ok && !I_IRQ_ACK;
      O_IRQ_VECTOR <= `EINP_VEC_BASE + `EINP_VEC_STEP * {5'h00, grant_idx};
      sel_hi_r     <= grant_hi;
      sel_idx_r    <= grant_idx;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_IRQ_ACK_SRC <= 8'h00;
    end else begin
      O_IRQ_ACK_SRC <= ack_src_nxt;
    end
  end

  // in-service levels: return releases the higher active level first
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      isr_hi_r <= 1'b0;
      isr_lo_r <= 1'b0;
    end else if (I_IRQ_ACK && O_IRQ_REQ) begin
      if (sel_hi_r) begin
        isr_hi_r <= 1'b1;
      end else begin
        isr_lo_r <= 1'b1;
      end
    end else if (I_IRQ_RETI) begin
      if (isr_hi_r) begin
        isr_hi_r <= 1'b0;
      end else begin
        isr_lo_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_EXT_ZERO_ONE_PENDING <= 2'b00;
    end else begin
      O_EXT_ZERO_ONE_PENDING <= ext_pend[1:0];
    end
  end

  // ==========================================================
  // four-bit port
  // ==========================================================
  logic [3:0] port_r;

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      port_r <= `EINP_RST_PORT;
    end else if (wr_port) begin
      port_r <= I_SFR_WDATA[3:0];
    end else if (bwr_port) begin
      port_r[bit_idx[1:0]] <= I_BIT_WDATA;
    end
  end

  // a zero latch pulls the pin low; a one releases it to the pull-up
  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_AUX_NIBBLE_PORT_OUT  <= 4'h0;
      O_AUX_NIBBLE_PORT_OE_N <= 4'hF;
    end else begin
      O_AUX_NIBBLE_PORT_OUT  <= 4'h0;
      O_AUX_NIBBLE_PORT_OE_N <= port_r;
    end
  end

  // ==========================================================
  // read-back
  // ==========================================================
  logic [7:0] xctrl_view;
  logic [3:0] port_view;

  assign xctrl_view = {xctrl_r[7:6], ext_pend[3], xctrl_r[4:2], ext_pend[2], xctrl_r[0]};
  // read-modify-write reads the latch, a plain read reads the pins
  assign port_view  = I_SFR_RMW ? port_r : port_pin_s;

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_SFR_RDATA <= 8'h00;
      O_SFR_HIT   <= 1'b0;
    end else if (I_SFR_RD) begin
      case (I_SFR_ADDR)
        `EINP_ADDR_XCTRL: begin
          O_SFR_RDATA <= xctrl_view;
          O_SFR_HIT   <= 1'b1;
        end
        `EINP_ADDR_PORT: begin
          O_SFR_RDATA <= {`EINP_PORT_UNUSED, port_view};
          O_SFR_HIT   <= 1'b1;
        end
        default: begin
          O_SFR_RDATA <= 8'h00;
          O_SFR_HIT   <= 1'b0;
        end
      endcase
    end else begin
      O_SFR_HIT <= 1'b0;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_SRST) begin
      O_BIT_RDATA <= 1'b0;
    end else if (I_BIT_RD) begin
      if (bit_xctrl) begin
        O_BIT_RDATA <= xctrl_view[bit_idx];
      end else if (bit_port) begin
        O_BIT_RDATA <= I_SFR_RMW ? port_r[bit_idx[1:0]] : port_pin_s[bit_idx[1:0]];
      end else begin
        O_BIT_RDATA <= 1'b0;
      end
    end
  end

endmodule // einp_ext_irq_and_nibble_port

`default_nettype wire

// *** test/einp_asserts.sv ***
// checker for the extra interrupt block: register bus, port pins and vector handshake
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ns
`default_nettype none

module einp_asserts (
  input wire logic       I_MCLK,
  input wire logic       I_SRST,
  input wire logic [7:0] I_SFR_ADDR,
  input wire logic       I_SFR_WR,
  input wire logic [7:0] I_SFR_WDATA,
  input wire logic       I_SFR_RD,
  input wire logic       I_SFR_RMW,
  input wire logic [7:0] O_SFR_RDATA,
  input wire logic       O_SFR_HIT,
  input wire logic [7:0] I_IRQ_ENABLE_REG,
  input wire logic [3:0] O_AUX_NIBBLE_PORT_OUT,
  input wire logic [3:0] O_AUX_NIBBLE_PORT_OE_N,
  input wire logic       O_IRQ_REQ,
  input wire logic [7:0] O_IRQ_VECTOR,
  input wire logic [7:0] O_IRQ_ACK_SRC,
  input wire logic       I_IRQ_ACK
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_SRST);

  // ====
  // register bus
  property p_hit_mapped;
    I_SFR_RD && (I_SFR_ADDR == 8'hC0 || I_SFR_ADDR == 8'hD8) |=> O_SFR_HIT;
  endproperty
  a_hit_mapped: assert property (p_hit_mapped)
    else $error("no hit after mapped read");
  property p_unmapped;
    I_SFR_RD && I_SFR_ADDR != 8'hC0 && I_SFR_ADDR != 8'hD8 |=> !O_SFR_HIT && O_SFR_RDATA == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read answered");
  property p_upper_zero;
    I_SFR_RD && I_SFR_ADDR == 8'hD8 |=> O_SFR_RDATA[7:4] == 4'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("port upper nibble not zero");

  // ====
  // port pins
  property p_oe_follow;
    I_SFR_WR && I_SFR_ADDR == 8'hD8 |-> ##2 O_AUX_NIBBLE_PORT_OE_N == 4'($past(I_SFR_WDATA, 2));
  endproperty
  a_oe_follow: assert property (p_oe_follow)
    else $error("pin drive does not follow latch");
  property p_out_low;
    O_AUX_NIBBLE_PORT_OUT == 4'h0;
  endproperty
  a_out_low: assert property (p_out_low)
    else $error("port drives high");

  // ====
  // vectoring
  property p_vec_form;
    O_IRQ_REQ |-> O_IRQ_VECTOR[2:0] == 3'h3 && O_IRQ_VECTOR[7:6] == 2'h0;
  endproperty
  a_vec_form: assert property (p_vec_form)
    else $error("vector off the table");
  property p_ack_src;
    I_IRQ_ACK && O_IRQ_REQ |=>
      O_IRQ_ACK_SRC == 8'h01 << (($past(O_IRQ_VECTOR) >> 3) & 8'h07) && !O_IRQ_REQ;
  endproperty
  a_ack_src: assert property (p_ack_src)
    else $error("acknowledged source wrong");
  property p_gate;
    !I_IRQ_ENABLE_REG[7] [*3] |-> !O_IRQ_REQ;
  endproperty
  a_gate: assert property (p_gate)
    else $error("request while globally disabled");
endmodule // einp_asserts

bind einp_ext_irq_and_nibble_port einp_asserts i_einp_asserts (.*);

`default_nettype wire

// *** test/einp_src_model.sv ***
// external interrupt sources and pin loads of the four-bit port
// assumes the bench pulses set per source and clears all sources at once; pins pulled up when released
`timescale 1ns/1ns
`default_nettype none

module einp_src_model (
  input  wire logic       i_clk,
  input  wire logic [5:0] i_set,
  input  wire logic [5:0] i_clr,
  input  wire logic [3:0] i_oe_n,
  output logic      [3:0] o_port_pin,
  output logic            o_zero_pin,
  output logic            o_one_pin
);
  // bits 3..0 port pins, 4 zero pin, 5 one pin; a source holds low until cleared
  logic [5:0] low_r;
  always_ff @(posedge i_clk) begin
    low_r <= (low_r | i_set) & ~i_clr;
  end
  assign o_port_pin = i_oe_n & ~low_r[3:0];
  assign o_zero_pin = ~low_r[4];
  assign o_one_pin  = ~low_r[5];
endmodule // einp_src_model

`default_nettype wire

// *** test/tb_ext_irq_and_nibble_port.sv ***
// self-checking bench for the extra interrupts and four-bit port
// assumes einp_src_model stands for the pins and the bench plays the core
`timescale 1ns/1ns
`default_nettype none

module tb_ext_irq_and_nibble_port;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rmw = 1'b0;
  logic       bwr = 1'b0, bwd = 1'b0, brd = 1'b0, ack = 1'b0, reti = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, baddr = 8'h00, ie = 8'h00, d, r;
  logic [3:0] stdi = 4'h0, pin, pout, oe_n;
  logic [5:0] set_s = 6'h00, clr_s = 6'h3F;
  logic [7:0] rdata, vec, asrc, timer_ctrl_reg = 8'h00;
  logic       hit, brdata, req, z_pin, o_pin;
  logic [1:0] zo;
  int         n_errors = 0, comparisons = 0, cyc = 0;

  always #20 clk = ~clk;

  einp_ext_irq_and_nibble_port i_einp_ext_irq_and_nibble_port (
    .I_MCLK(clk), .I_SRST(rst), .I_SFR_ADDR(addr), .I_SFR_WR(wr), .I_SFR_WDATA(wd),
    .I_SFR_RD(rd), .I_SFR_RMW(rmw), .O_SFR_RDATA(rdata), .O_SFR_HIT(hit),
    .I_BIT_ADDR(baddr), .I_BIT_WR(bwr), .I_BIT_WDATA(bwd), .I_BIT_RD(brd),
    .O_BIT_RDATA(brdata), .I_IRQ_ENABLE_REG(ie), .I_TIMER_CTRL_REG(timer_ctrl_reg),
    .I_STD_PRIORITY(6'h00), .I_STD_IRQ(stdi), .I_EXT_IRQ_ZERO_PIN(z_pin),
    .I_EXT_IRQ_ONE_PIN(o_pin), .I_AUX_NIBBLE_PORT_IN(pin), .O_AUX_NIBBLE_PORT_OUT(pout),
    .O_AUX_NIBBLE_PORT_OE_N(oe_n), .O_IRQ_REQ(req), .O_IRQ_VECTOR(vec),
    .O_IRQ_ACK_SRC(asrc), .O_EXT_ZERO_ONE_PENDING(zo), .I_IRQ_ACK(ack), .I_IRQ_RETI(reti)
  );

  einp_src_model i_einp_src_model (
    .i_clk(clk), .i_set(set_s), .i_clr(clr_s), .i_oe_n(oe_n),
    .o_port_pin(pin), .o_zero_pin(z_pin), .o_one_pin(o_pin)
  );

  // ====
  // helpers
  function automatic logic [7:0] vec_of(input int i);
    return 8'h03 + 8'(8 * i);
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_b(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_b(input logic [7:0] a, input logic m);
    @(posedge clk);
    addr <= a;
    rmw <= m;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    chk("hit", {7'h00, hit}, {7'h00, a == 8'hC0 || a == 8'hD8});
  endtask

  task automatic bit_op(input logic [7:0] a, input logic w, input logic v);
    @(posedge clk);
    baddr <= a;
    bwd <= v;
    bwr <= w;
    brd <= ~w;
    @(posedge clk);
    bwr <= 1'b0;
    brd <= 1'b0;
    #1;
    if (!w) chk("bit", {7'h00, brdata}, {7'h00, v});
  endtask

  task automatic raise(input int i);
    @(posedge clk);
    case (i)
      0: set_s <= 6'h10;
      2: set_s <= 6'h20;
      6: set_s <= 6'h04;
      7: set_s <= 6'h08;
      default: stdi <= stdi | 4'(1 << ((i == 1) ? 0 : i - 2));
    endcase
    @(posedge clk);
    set_s <= 6'h00;
  endtask

  task automatic both(input int a, input int b);
    @(posedge clk);
    ie <= 8'h00;
    raise(a);
    raise(b);
    tick(40);
    ie <= 8'hBF;
  endtask

  task automatic service(input int i);
    int k;
    k = 0;
    #1;
    while (req !== 1'b1 && k < 80) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("vector", vec, vec_of(i));
    if (i == 0 || i == 2) chk("zo_pend", {6'h00, zo}, 8'(i / 2 + 1));
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    #1;
    chk("ack_src", asrc, 8'h01 << i);
    chk("req", {7'h00, req}, 8'h00);
    @(posedge clk);
    clr_s <= 6'h3F;
    stdi <= 4'h0;
    tick(30);
    clr_s <= 6'h00;
    reti <= 1'b1;
    @(posedge clk);
    reti <= 1'b0;
    tick(30);
  endtask

  task automatic end_sim;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  // ====
  // tests
  initial begin
    void'($urandom(32'h0c39_f3fc));
    tick(16);
    rst <= 1'b0;
    clr_s <= 6'h00;
    tick(2);
    #1;
    chk("oe_n", {4'h0, oe_n}, 8'h0F);
    chk("out", {4'h0, pout}, 8'h00);
    rd_b(8'hC0, 1'b0);
    chk("ctrl", d, 8'h00);
    rd_b(8'hD8, 1'b1);
    chk("latch", d, 8'h0F);
    $display("test reset done");
    for (int n = 0; n < 8; n++) begin
      r = 8'($urandom) & 8'hDD;
      wr_b(8'hC0, r);
      rd_b(8'hC0, 1'b0);
      chk("ctrl", d, r);
      wr_b(8'hD8, r | 8'h0C);
      rd_b(8'hD8, 1'b1);
      chk("latch", d, {4'h0, r[3:0] | 4'hC});
      tick(4);
      chk("oe_n", {4'h0, oe_n}, {4'h0, r[3:0] | 4'hC});
      rd_b(8'hD8, 1'b0);
      chk("pins", d, {4'h0, r[3:0] | 4'hC});
    end
    rd_b(8'h80, 1'b0);
    chk("unmapped", d, 8'h00);
    $display("test registers done");
    wr_b(8'hC0, 8'h00);
    wr_b(8'hD8, 8'h0F);
    bit_op(8'hC2, 1'b1, 1'b1);
    rd_b(8'hC0, 1'b0);
    chk("ctrl", d, 8'h04);
    bit_op(8'hC2, 1'b0, 1'b1);
    bit_op(8'hD9, 1'b1, 1'b0);
    bit_op(8'hDC, 1'b1, 1'b0);
    bit_op(8'hD9, 1'b0, 1'b0);
    rd_b(8'hD8, 1'b1);
    chk("latch", d, 8'h0D);
    wr_b(8'hD8, 8'h0F);
    $display("test bits done");
    @(posedge clk);
    ie <= 8'hBF;
    wr_b(8'hC0, 8'h55);
    for (int i = 0; i < 8; i++) begin
      raise(i);
      service(i);
    end
    $display("test vectors done");
    both(6, 1);
    service(1);
    service(6);
    wr_b(8'hC0, 8'h5D);
    both(1, 6);
    service(6);
    $display("test priority done");
    wr_b(8'hC0, 8'h11);
    raise(6);
    tick(40);
    #1;
    chk("req", {7'h00, req}, 8'h00);
    rd_b(8'hC0, 1'b0);
    chk("ctrl", d, 8'h13);
    bit_op(8'hC2, 1'b1, 1'b1);
    service(6);
    rd_b(8'hC0, 1'b0);
    chk("ctrl", d, 8'h15);
    wr_b(8'hC0, 8'h04);
    raise(6);
    tick(40);
    #1;
    chk("req", {7'h00, req}, 8'h01);
    @(posedge clk);
    clr_s <= 6'h3F;
    tick(40);
    #1;
    chk("req", {7'h00, req}, 8'h00);
    // zero pin in edge mode: request latched on the falling edge stays pending after the pin is released
    @(posedge clk);
    clr_s <= 6'h00;
    timer_ctrl_reg <= 8'h05;
    raise(0);
    tick(30);
    clr_s <= 6'h3F;
    tick(30);
    #1;
    chk("zo_pend", {6'h00, zo}, 8'h01);
    service(0);
    chk("zo_pend", {6'h00, zo}, 8'h00);
    $display("test trigger done");
    end_sim();
  end
endmodule // tb_ext_irq_and_nibble_port

`default_nettype wire
